//--- design/cipher_engine_params.svh
// address map, field positions and timing figures of the cipher engine
`ifndef CIPHER_ENGINE_PARAMS_SVH
`define CIPHER_ENGINE_PARAMS_SVH
`define ADDR_STATUS 8'h82
`define ADDR_CTRL 8'h83
`define ADDR_BLK_FIRST 8'h84
`define ADDR_BLK_LAST 8'h93
`define ADDR_CTRL_COPY 8'h94
`define CTRL_REQ_BIT 7
`define CTRL_MODE_MSB 6
`define CTRL_MODE_LSB 4
`define CTRL_DIR_BIT 3
`define STATUS_DONE_BIT 0
`define BLOCK_BYTES 16
`define CIPHER_ROUNDS 10
`define CLK_PERIOD_PS 4000
`define T_RUN_NS 23400
`define T_RUN_MAX_NS 24000
`endif

//--- design/cipher_engine_pkg.sv
// shared types of the cipher engine
package cipher_engine_pkg;
	typedef enum logic [2:0] {
		MODE_ECB = 3'b000,
		MODE_KEY = 3'b001,
		MODE_CBC = 3'b010
	} cipher_mode_t;
	typedef enum logic {
		CORE_IDLE = 1'b0,
		CORE_RUN = 1'b1
	} core_state_t;
endpackage

//--- design/engine_if.sv
// carrier between the control logic, the round core and the page store
`timescale 1ns/1ps
interface engine_if;
	logic clr;
	logic start;
	logic decrypt;
	logic chain;
	logic [127:0] key;
	logic [127:0] block;
	logic [127:0] result;
	logic [127:0] last_key;
	logic busy;
	logic done;
	logic wr_en;
	logic wr_page;
	logic [3:0] wr_idx;
	logic [7:0] wr_byte;
	logic [3:0] rd_idx;
	logic [7:0] rd_byte;
	modport ctrl(output clr, start, decrypt, chain, wr_en, wr_page, wr_idx, wr_byte, rd_idx,
		input key, block, result, last_key, busy, done, rd_byte);
	modport core(input clr, start, decrypt, chain, key, block,
		output result, last_key, busy, done);
	modport mem(input clr, wr_en, wr_page, wr_idx, wr_byte, rd_idx, result, done,
		output key, block, rd_byte);
endinterface

//--- design/cipher_page_store.sv
// two 16-byte pages: loaded key and data block, registered byte read
`timescale 1ns/1ps
`include "cipher_engine_params.svh"
module cipher_page_store (
	// clock
	input wire logic clk_sys,
	// engine side
	engine_if.mem eng
);
	import cipher_engine_pkg::*;
	logic [127:0] key_q;
	logic [127:0] next_key;
	logic [127:0] blk_q;
	logic [127:0] next_blk;
	logic [7:0] rd_q;
	logic [7:0] next_rd;

	genvar i;
	generate
		for (i = 0; i < `BLOCK_BYTES; i++) begin : g_byte
			always_comb begin
				next_key[8*i +: 8] = key_q[8*i +: 8];
				next_blk[8*i +: 8] = blk_q[8*i +: 8];
				// host write lands after the result so it overwrites it
				if (eng.done) begin
					next_blk[8*i +: 8] = eng.result[8*i +: 8];
				end
				if (eng.wr_en && eng.wr_idx == 4'(i)) begin
					if (eng.wr_page) begin
						next_key[8*i +: 8] = eng.wr_byte;
					end else begin
						next_blk[8*i +: 8] = eng.wr_byte;
					end
				end
				if (eng.clr) begin
					next_key[8*i +: 8] = 8'h00;
					next_blk[8*i +: 8] = 8'h00;
				end
			end
		end
	endgenerate

	always_comb begin
		next_rd = eng.clr ? 8'h00 : blk_q[8*eng.rd_idx +: 8];
	end

	always_ff @(posedge clk_sys) begin
		key_q <= next_key;
		blk_q <= next_blk;
		rd_q <= next_rd;
	end

	assign eng.key = key_q;
	assign eng.block = blk_q;
	assign eng.rd_byte = rd_q;
endmodule

//--- design/cipher_round_core.sv
// iterative round engine, one round per step enable
`timescale 1ns/1ps
`include "cipher_engine_params.svh"
module cipher_round_core #(
	parameter int ROUNDS = `CIPHER_ROUNDS,
	parameter int STEP_CYCLES = 585
) (
	// clock
	input wire logic clk_sys,
	// engine side
	engine_if.core eng
);
	import cipher_engine_pkg::*;
	core_state_t state, next_state;
	logic [127:0] st, next_st, rk, next_rk, lk, next_lk, chain_q, next_chain;
	logic [127:0] rk_e, sd, rk_x;
	logic dir_q, next_dir, done_q, next_done;
	logic [15:0] div, next_div;
	logic [7:0] rnd, next_rnd;

	generate
		if (ROUNDS < 1 || ROUNDS > 255 || STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_chk
			$error("cipher_round_core: unsupported round or step count");
		end
	endgenerate

	always_comb begin
		next_state = state;
		next_st = st;
		next_rk = rk;
		next_lk = lk;
		next_chain = chain_q;
		next_dir = dir_q;
		next_div = div;
		next_rnd = rnd;
		next_done = 1'b0;
		rk_e = {rk[119:0], rk[127:120]} ^ {rnd, 120'h0};
		sd = st ^ rk;
		rk_x = rk ^ {rnd, 120'h0};
		unique case (state)
			CORE_IDLE: begin
				if (eng.start) begin
					next_state = CORE_RUN;
					next_dir = eng.decrypt;
					next_div = 16'h0000;
					next_rk = eng.key; // working copy, loaded page untouched
					next_st = eng.chain ? (eng.block ^ chain_q) : eng.block;
					next_rnd = eng.decrypt ? 8'(ROUNDS) : 8'h01;
				end
			end
			CORE_RUN: begin
				if (div == 16'(STEP_CYCLES - 1)) begin
					next_div = 16'h0000;
					if (!dir_q) begin
						next_rk = rk_e;
						next_st = {st[119:0], st[127:120]} ^ rk_e;
						next_rnd = rnd + 8'h01;
					end else begin
						// walk the schedule backwards from the final round key
						next_st = {sd[7:0], sd[127:8]};
						next_rk = {rk_x[7:0], rk_x[127:8]};
						next_rnd = rnd - 8'h01;
					end
					if ((!dir_q && rnd == 8'(ROUNDS)) || (dir_q && rnd == 8'h01)) begin
						next_state = CORE_IDLE;
						next_done = 1'b1;
						next_lk = next_rk;
						next_chain = next_st;
					end
				end else begin
					next_div = div + 16'h0001;
				end
			end
		endcase
		if (eng.clr) begin
			next_state = CORE_IDLE;
			next_st = '0;
			next_rk = '0;
			next_lk = '0;
			next_chain = '0;
			next_dir = 1'b0;
			next_div = 16'h0000;
			next_rnd = 8'h00;
			// a step ending on the reset edge must not leave a completion behind
			next_done = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		state <= next_state;
		st <= next_st;
		rk <= next_rk;
		lk <= next_lk;
		chain_q <= next_chain;
		dir_q <= next_dir;
		div <= next_div;
		rnd <= next_rnd;
		done_q <= next_done;
	end

	assign eng.result = st;
	assign eng.last_key = lk;
	assign eng.busy = (state == CORE_RUN);
	assign eng.done = done_q;
endmodule

//--- design/cipher_engine.sv
// cipher engine control: memory-style window, control, status and read path
// Overview of operation
// - key load: mode field 1 in control, then key bytes at 0x84..0x93
// - key and data share addresses on separate pages picked by mode
// - reading the key page returns the last round key of prior run
// - loaded key stays unchanged and is reused by the next run
// - block to process sits in data addresses 0x84..0x93
// - writing request bit 1 at 0x83 or 0x94 starts a run
// - engine reachable only by reads and writes within 0x82..0x94
// - mode, data and start may share one burst, taken in address order
// - no access outside the window is needed to run the engine
// - accesses refused while transceiver sleeps or is in reset
// - reset state clears configuration, block contents and keys
// - result is placed in the data block addresses for read back
// - decryption supported in code book mode besides encryption
// - mode 0 code book, 1 key loading, 2 block chaining
// - completion flag at 0x82 set within 24 us of the start
`timescale 1ns/1ps
`include "cipher_engine_params.svh"
module cipher_engine #(
	parameter int RUN_CYCLES = (`T_RUN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// transceiver power state
	input wire logic trx_sleep,
	input wire logic trx_reset,
	// memory-style access port
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [7:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	// state seen from outside
	output logic engine_busy,
	output cipher_engine_pkg::cipher_mode_t engine_mode
);
	import cipher_engine_pkg::*;

	localparam int MAX_CYCLES = (`T_RUN_MAX_NS * 1000) / `CLK_PERIOD_PS;
	localparam int STEP_CYCLES = RUN_CYCLES / `CIPHER_ROUNDS;

	generate
		if (RUN_CYCLES < `CIPHER_ROUNDS || RUN_CYCLES > MAX_CYCLES) begin : g_chk
			$error("cipher_engine: RUN_CYCLES outside the allowed run time");
		end
	endgenerate

	engine_if eng ();

	cipher_round_core #(
		.ROUNDS(`CIPHER_ROUNDS),
		.STEP_CYCLES(STEP_CYCLES)
	) u_core (
		.clk_sys(clk_sys),
		.eng(eng.core)
	);

	cipher_page_store u_store (
		.clk_sys(clk_sys),
		.eng(eng.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic clr;
	logic acc_ok;
	logic wr;
	logic rd;
	logic in_blk;
	logic ctrl_hit;
	logic [3:0] idx;
	logic start;
	cipher_mode_t wr_mode;

	assign clr = sys_rst || trx_reset;
	assign acc_ok = !trx_sleep && !trx_reset;
	assign wr = acc_wr && acc_ok;
	assign rd = acc_rd && acc_ok;
	// only the window decodes; nothing outside it steers the engine
	assign in_blk = (acc_addr >= `ADDR_BLK_FIRST) && (acc_addr <= `ADDR_BLK_LAST);
	assign ctrl_hit = wr && (acc_addr == `ADDR_CTRL || acc_addr == `ADDR_CTRL_COPY);
	assign idx = 4'(acc_addr - `ADDR_BLK_FIRST);
	// mode field of the byte on the bus, seen before it is stored
	assign wr_mode = cipher_mode_t'(acc_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	// starts ignored while a run is in flight
	assign start = ctrl_hit && acc_wdata[`CTRL_REQ_BIT] && !eng.busy;

	////////////////////////////////////////////////////////////////////////
	// control and status

	cipher_mode_t mode_q, next_mode;
	logic dir_q, next_dir;
	logic done_q, next_done;

	always_comb begin
		next_mode = mode_q;
		next_dir = dir_q;
		next_done = done_q;
		if (ctrl_hit) begin
			next_mode = wr_mode;
			next_dir = acc_wdata[`CTRL_DIR_BIT];
		end
		if (start) begin
			next_done = 1'b0;
		end
		// result is in the block page on this same edge
		if (eng.done) begin
			next_done = 1'b1;
		end
		if (clr) begin
			next_mode = MODE_ECB;
			next_dir = 1'b0;
			next_done = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		mode_q <= next_mode;
		dir_q <= next_dir;
		done_q <= next_done;
	end

	// each byte acts as it arrives, so one burst may set mode, fill and start
	assign eng.clr = clr;
	assign eng.start = start;
	assign eng.decrypt = acc_wdata[`CTRL_DIR_BIT];
	assign eng.chain = (wr_mode == MODE_CBC);
	assign eng.wr_en = wr && in_blk;
	assign eng.wr_page = (mode_q == MODE_KEY);
	assign eng.wr_idx = idx;
	assign eng.wr_byte = acc_wdata;
	assign eng.rd_idx = idx;
	assign engine_busy = eng.busy;
	assign engine_mode = mode_q;

	////////////////////////////////////////////////////////////////////////
	// read path, two cycles to line up with the registered page store

	logic [7:0] side_q, next_side;
	logic sel_q, next_sel;
	logic rv1_q, next_rv1;
	logic [7:0] rdata_q, next_rdata;
	logic rv2_q, next_rv2;
	logic [7:0] ctrl_rd;

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode_q;
		ctrl_rd[`CTRL_DIR_BIT] = dir_q;
		next_side = 8'h00;
		next_sel = 1'b0;
		next_rv1 = rd;
		if (rd) begin
			if (acc_addr == `ADDR_STATUS) begin
				next_side[`STATUS_DONE_BIT] = done_q;
			end else if (acc_addr == `ADDR_CTRL || acc_addr == `ADDR_CTRL_COPY) begin
				next_side = ctrl_rd;
			end else if (in_blk && mode_q == MODE_KEY) begin
				next_side = eng.last_key[8*idx +: 8];
			end else if (in_blk) begin
				next_sel = 1'b1;
			end
		end
		// page store byte lands a cycle late, so the data page waits on sel_q
		next_rdata = sel_q ? eng.rd_byte : side_q;
		next_rv2 = rv1_q;
		if (clr) begin
			next_side = 8'h00;
			next_sel = 1'b0;
			next_rv1 = 1'b0;
			next_rdata = 8'h00;
			next_rv2 = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		side_q <= next_side;
		sel_q <= next_sel;
		rv1_q <= next_rv1;
		rdata_q <= next_rdata;
		rv2_q <= next_rv2;
	end

	assign acc_rdata = rdata_q;
	assign acc_rvalid = rv2_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	logic [15:0] run_cnt;

	always_ff @(posedge clk_sys) begin
		if (clr || !eng.busy) begin
			run_cnt <= 16'h0000;
		end else begin
			run_cnt <= run_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// run timing and completion flag
	run_time_a: assert property (eng.busy |-> run_cnt < 16'(MAX_CYCLES))
		else $error("run exceeds the allowed time");
	done_clear_a: assert property (start |=> !done_q && eng.busy)
		else $error("start did not clear done");
	done_hold_a: assert property (eng.busy && !eng.done |=> !done_q)
		else $error("done set before result stored");
	result_stored_a: assert property (eng.done && !eng.wr_en && !clr |=> done_q &&
		eng.block == $past(eng.result))
		else $error("result not placed in block page");
	run_length_a: assert property (eng.done |->
		run_cnt == 16'(STEP_CYCLES * `CIPHER_ROUNDS))
		else $error("run length differs from the step count");

	// page stores, mode and direction
	key_kept_a: assert property (eng.busy && !eng.wr_en && !clr |=>
		$stable(eng.key))
		else $error("loaded key changed during run");
	page_select_a: assert property (wr && in_blk && mode_q == MODE_KEY &&
		!eng.done |=> $stable(eng.block))
		else $error("key write reached data page");
	key_write_a: assert property (wr && in_blk && mode_q == MODE_KEY |=>
		eng.key[8*$past(idx) +: 8] == $past(acc_wdata))
		else $error("key byte not stored at its index");
	data_write_a: assert property (wr && in_blk && mode_q != MODE_KEY |=>
		eng.block[8*$past(idx) +: 8] == $past(acc_wdata))
		else $error("data byte not stored at its index");
	outside_write_a: assert property (wr && !in_blk && !ctrl_hit && !eng.done |=>
		$stable(eng.key) && $stable(eng.block) && $stable(mode_q))
		else $error("write outside the window changed the engine");
	mode_hold_a: assert property (!ctrl_hit && !clr |=>
		$stable(mode_q))
		else $error("mode changed without a control write");
	dir_store_a: assert property (ctrl_hit && !clr |=>
		dir_q == $past(acc_wdata[`CTRL_DIR_BIT]))
		else $error("direction not taken from the control byte");

	// power states and reset
	refuse_sleep_a: assert property (trx_sleep && !trx_reset |=>
		$stable(mode_q) ##1 !acc_rvalid)
		else $error("access taken during sleep");
	sleep_write_a: assert property (acc_wr && trx_sleep && !trx_reset && !eng.done |=>
		$stable(eng.key) && $stable(eng.block))
		else $error("write stored during sleep");
	reset_clear_a: assert property (trx_reset |=> mode_q == MODE_ECB && !done_q &&
		eng.key == '0 && eng.block == '0 && !eng.busy)
		else $error("reset state left contents");

	// read paths and run start
	key_read_a: assert property (rd && in_blk && mode_q == MODE_KEY && !eng.busy
		&& !trx_reset ##1 !trx_reset[*2] |-> acc_rvalid &&
		acc_rdata == $past(eng.last_key[8*idx +: 8], 2))
		else $error("key page read wrong");
	outside_read_a: assert property (rd && !in_blk && acc_addr != `ADDR_STATUS &&
		acc_addr != `ADDR_CTRL && acc_addr != `ADDR_CTRL_COPY ##1 !trx_reset[*2] |->
		acc_rvalid && acc_rdata == 8'h00)
		else $error("read outside window not zero");
	read_latency_a: assert property (rd ##1 !clr |=>
		acc_rvalid)
		else $error("read answer not two cycles after the access");
	idle_rdata_a: assert property (!acc_rvalid |->
		acc_rdata == 8'h00)
		else $error("read data not zero outside an answer");
	status_read_a: assert property (rd && acc_addr == `ADDR_STATUS ##1 !clr |=>
		acc_rdata[`STATUS_DONE_BIT] == $past(done_q, 2))
		else $error("status read does not show the completion flag");
	ctrl_read_a: assert property (rd && (acc_addr == `ADDR_CTRL ||
		acc_addr == `ADDR_CTRL_COPY) ##1 !clr |=>
		acc_rdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == $past(mode_q, 2) &&
		!acc_rdata[`CTRL_REQ_BIT])
		else $error("control read does not show the mode");
	start_req_a: assert property (ctrl_hit && acc_wdata[`CTRL_REQ_BIT] && !eng.busy &&
		!clr |=> eng.busy)
		else $error("request bit did not start a run");

	// run kind latched at start: a full run outlasts any delay range a cover may use
	logic run_dec;
	logic run_cbc;

	always_ff @(posedge clk_sys) begin
		if (start) begin
			run_dec <= eng.decrypt;
			run_cbc <= eng.chain;
		end
	end

	ecb_enc_c: cover property (eng.done && !run_dec && !run_cbc);
	ecb_dec_c: cover property (eng.done && run_dec);
	cbc_run_c: cover property (eng.done && run_cbc);
	key_load_c: cover property (eng.wr_en && eng.wr_page);
	key_read_c: cover property (rd && in_blk && mode_q == MODE_KEY);
endmodule

//--- tb/host_model.sv
// host model: memory-style byte accesses into the engine window
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic clk_sys,
	// access port
	output logic acc_wr,
	output logic acc_rd,
	output logic [7:0] acc_addr,
	output logic [7:0] acc_wdata,
	input wire logic [7:0] acc_rdata,
	input wire logic acc_rvalid
);
	initial begin
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_addr = 8'h00;
		acc_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////
	// released lines show the inverse, so a stale byte never looks valid
	task automatic burst(input logic [7:0] a, input logic [7:0] d[$]);
		@(posedge clk_sys);
		#1;
		acc_wr = 1'b1;
		foreach (d[i]) begin
			acc_addr = a + 8'(i);
			acc_wdata = d[i];
			@(posedge clk_sys);
			#1;
		end
		acc_wr = 1'b0;
		acc_addr = ~acc_addr;
		acc_wdata = ~acc_wdata;
	endtask
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q[$];
		q.push_back(d);
		burst(a, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		d = 8'hxx;
		ok = 1'b0;
		@(posedge clk_sys);
		#1;
		acc_rd = 1'b1;
		acc_addr = a;
		@(posedge clk_sys);
		#1;
		acc_rd = 1'b0;
		acc_addr = ~a;
		repeat (4) begin
			if (!ok && acc_rvalid === 1'b1) begin
				d = acc_rdata;
				ok = 1'b1;
			end
			@(posedge clk_sys);
			#1;
		end
	endtask
	////////////////////////////////////////////////////////////
	// key mode and whole key in one burst from the control byte
	task automatic load_key(input logic [127:0] k);
		logic [7:0] q[$];
		q.push_back(8'h10);
		for (int i = 0; i < 16; i++) q.push_back(k[8*i +: 8]);
		burst(8'h83, q);
	endtask
	// mode, direction, block and optional start byte in address order
	task automatic fill(input logic [127:0] b, input logic [7:0] c, input logic go);
		logic [7:0] q[$];
		q.push_back(c);
		for (int i = 0; i < 16; i++) q.push_back(b[8*i +: 8]);
		if (go) q.push_back(c | 8'h80);
		burst(8'h83, q);
	endtask
	task automatic read_block(output logic [127:0] blk);
		logic [7:0] d;
		logic ok;
		for (int i = 0; i < 16; i++) begin
			rd(8'h84 + 8'(i), d, ok);
			blk[8*i +: 8] = d;
		end
	endtask
endmodule

//--- tb/tb_top.sv
// top-level self-checking bench for the cipher engine
`timescale 1ns/1ps
module tb_top;
	import cipher_engine_pkg::*;
	localparam int RUN = 20;
	logic clk_sys, sys_rst, trx_sleep, trx_reset, acc_wr, acc_rd, acc_rvalid, engine_busy, ok;
	logic [7:0] acc_addr, acc_wdata, acc_rdata, b, e;
	logic [127:0] key, lkey, p1, p2, c1, c2, r;
	cipher_mode_t engine_mode;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	int t0;
	cipher_engine #(.RUN_CYCLES(RUN)) i_cipher_engine (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.trx_sleep(trx_sleep), .trx_reset(trx_reset), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.acc_rvalid(acc_rvalid), .engine_busy(engine_busy), .engine_mode(engine_mode));
	host_model i_host_model (.clk_sys(clk_sys), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.acc_rvalid(acc_rvalid));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] x);
		check_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: byte %h, expected %h", $time, g, x);
		end
	endtask
	task automatic chk128(input logic [127:0] g, input logic [127:0] x);
		check_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: block %h, expected %h", $time, g, x);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
		i_host_model.rd(a, b, ok);
		chk8(b, x);
	endtask
	function automatic logic [127:0] rnd();
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction
	// request bit reads back as 0, unused low bits too
	function automatic logic [7:0] ctrl_rb(input logic [7:0] w);
		return w & 8'h78;
	endfunction
	// shortened run: count steps plus the final store edge
	task automatic wait_done();
		while (engine_busy === 1'b1 && cycles - t0 < 500) begin
			@(posedge clk_sys);
			#1;
		end
		chk8({7'd0, cycles - t0 <= RUN + 2}, 8'h01);
		rdchk(8'h82, 8'h01);
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(74));
		sys_rst = 1'b1;
		trx_sleep = 1'b0;
		trx_reset = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		chk8({5'd0, engine_mode}, 8'h00);
		rdchk(8'h82, 8'h00);
		rdchk(8'h84, 8'h00);
		for (int m = 0; m < 3; m++) begin
			e = {1'b0, 3'(m), 1'(m), 3'b101};
			i_host_model.wr1(8'h83, e);
			chk8({5'd0, engine_mode}, {5'd0, 3'(m)});
			rdchk(8'h83, ctrl_rb(e));
			rdchk(8'h94, ctrl_rb(e));
		end
		i_host_model.wr1(8'h95, 8'hff);
		rdchk(8'h95, 8'h00);
		rdchk(8'h81, 8'h00);
		i_host_model.wr1(8'h83, 8'h10);
		rdchk(8'h84, 8'h00);
		key = rnd();
		p1 = rnd();
		p2 = rnd();
		i_host_model.load_key(key);
		i_host_model.fill(p1, 8'h00, 1'b1);
		t0 = cycles;
		chk8({7'd0, engine_busy}, 8'h01);
		rdchk(8'h82, 8'h00);
		i_host_model.wr1(8'h94, 8'h80);
		wait_done();
		chk8({7'd0, engine_busy}, 8'h00);
		i_host_model.wr1(8'h83, 8'h10);
		i_host_model.read_block(lkey);
		i_host_model.wr1(8'h83, 8'h00);
		i_host_model.read_block(c1);
		i_host_model.fill(p2, 8'h20, 1'b1);
		t0 = cycles;
		wait_done();
		i_host_model.read_block(c2);
		// decrypt the chained result with the first run's final key
		i_host_model.load_key(lkey);
		i_host_model.fill(c2, 8'h08, 1'b0);
		i_host_model.wr1(8'h83, 8'h88);
		t0 = cycles;
		wait_done();
		i_host_model.read_block(r);
		chk128(r, p2 ^ c1);
		i_host_model.wr1(8'h83, 8'h20);
		trx_sleep = 1'b1;
		i_host_model.wr1(8'h84, ~r[7:0]);
		i_host_model.rd(8'h84, b, ok);
		chk8({7'd0, ok}, 8'h00);
		trx_sleep = 1'b0;
		rdchk(8'h84, p2[7:0] ^ c1[7:0]);
		trx_reset = 1'b1;
		@(posedge clk_sys);
		#1;
		trx_reset = 1'b0;
		chk8({5'd0, engine_mode}, 8'h00);
		rdchk(8'h84, 8'h00);
		i_host_model.wr1(8'h83, 8'h10);
		rdchk(8'h84, 8'h00);
		summarize();
	end
endmodule
